//--- hw/pcmpb_pkg.sv
package pcmpb_pkg;

   // ************************************************
   // Register map
   // ************************************************

   // Register byte offsets.
   localparam logic [7:0] OFF_COMPARE_B_VALUE = 8'h00;
   localparam logic [7:0] OFF_CTRL = 8'h04;
   localparam logic [7:0] OFF_ACT = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0c;
   localparam logic [7:0] OFF_ACTV = 8'h10;

   // Field positions.
   localparam int POS_LOAD = 2;
   localparam int POS_DIRECT = 6;
   localparam int POS_PEND = 9;
   localparam int POS_ACT_A = 0;
   localparam int POS_ACT_B = 2;

   // Values after reset and fixed compare points.
   localparam logic [15:0] RST_COMPARE_B_VALUE = 16'h0000;
   localparam logic RST_DIRECT = 1'b0;
   localparam logic [15:0] TB_ZERO = 16'h0000;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************
   // Types
   // ************************************************

   // Shadow load event select.
   typedef enum logic [1:0] {LOAD_ZERO = 2'h0, LOAD_PRD = 2'h1, LOAD_BOTH = 2'h2, LOAD_FREEZE = 2'h3} pcmpb_load_t;

   // Action taken on an output at a compare B event.
   typedef enum logic [1:0] {ACT_NONE = 2'h0, ACT_CLEAR = 2'h1, ACT_SET = 2'h2, ACT_TOGGLE = 2'h3} pcmpb_act_t;

   // Time-base signals from the counter.
   typedef struct packed {
      logic [15:0] timebase_count;
      logic [15:0] timebase_period;
   } pcmpb_tb_t;

   // Action settings for both outputs.
   typedef struct packed {
      pcmpb_act_t act_a;
      pcmpb_act_t act_b;
   } pcmpb_aqcfg_t;

   // Merges the two low byte lanes of a bus write into a 16-bit value.
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data, input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction : merge16

endpackage : pcmpb_pkg

//--- hw/pcmpb_load.sv
`timescale 1ns/10ps
`default_nettype none
module pcmpb_load
   import pcmpb_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Time-base and compare value.
   input wire pcmpb_tb_t timebase,
   input wire logic [15:0] active_val,
   // Mode settings.
   input wire logic direct,
   input wire pcmpb_load_t load_sel,
   // Match and load strobes.
   output logic compare_b_value_equal,
   output logic load_stb,
   output logic compare_b_value_equal_evt
);
   typedef struct packed {
      logic equal_evt;
   } pcmpb_ldst_t;

   pcmpb_ldst_t st_r;
   pcmpb_ldst_t st_nxt;
   logic at_zero;
   logic at_prd;
   logic load_hit;

   // Continuous match of the active value against the count.
   assign compare_b_value_equal = (timebase.timebase_count == active_val);
   assign at_zero = (timebase.timebase_count == TB_ZERO);
   assign at_prd = (timebase.timebase_count == timebase.timebase_period);

   // Load select decode; immediate mode never loads.
   always_comb begin
      unique case (load_sel)
         LOAD_ZERO: load_hit = at_zero;
         LOAD_PRD: load_hit = at_prd;
         LOAD_BOTH: load_hit = at_zero || at_prd;
         LOAD_FREEZE: load_hit = 1'b0;
      endcase
      st_nxt = st_r;
      st_nxt.equal_evt = compare_b_value_equal;
   end
   assign load_stb = !direct && load_hit;
   assign compare_b_value_equal_evt = st_r.equal_evt;

   // State register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // The clock that leaves reset is skipped, as the event flop is still held there.
   a_match_event: assert property (compare_b_value_equal && $past(rst_n) |=> compare_b_value_equal_evt)
      else $error("Match did not raise the compare B event.");
   a_load_freeze: assert property (load_sel == LOAD_FREEZE |-> !load_stb)
      else $error("Load strobe while loads are frozen.");
   a_load_zero: assert property (!direct && load_sel == LOAD_ZERO && at_zero |-> load_stb)
      else $error("Zero count did not load in zero mode.");
endmodule : pcmpb_load
`default_nettype wire

//--- hw/pcmpb_aq.sv
`timescale 1ns/10ps
`default_nettype none
module pcmpb_aq
   import pcmpb_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Compare B event and action settings.
   input wire logic compare_b_value_equal,
   input wire pcmpb_aqcfg_t aq_cfg,
   // Qualified outputs.
   output logic pwm_out_a,
   output logic pwm_out_b
);
   typedef struct packed {
      logic out_a;
      logic out_b;
   } pcmpb_aqst_t;

   pcmpb_aqst_t st_r;
   pcmpb_aqst_t st_nxt;

   // Applies one action to the present level.
   function automatic logic act_apply(input pcmpb_act_t act, input logic cur);
      logic res;
      unique case (act)
         ACT_NONE: res = cur;
         ACT_CLEAR: res = 1'b0;
         ACT_SET: res = 1'b1;
         ACT_TOGGLE: res = !cur;
      endcase
      return res;
   endfunction : act_apply

   // Each output reacts to the event as its own setting says.
   always_comb begin
      st_nxt = st_r;
      if (compare_b_value_equal) begin
         st_nxt.out_a = act_apply(aq_cfg.act_a, st_r.out_a);
         st_nxt.out_b = act_apply(aq_cfg.act_b, st_r.out_b);
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign pwm_out_a = st_r.out_a;
   assign pwm_out_b = st_r.out_b;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_set_out_a: assert property (compare_b_value_equal && aq_cfg.act_a == ACT_SET |=> pwm_out_a)
      else $error("Set action did not drive output A high.");
   a_toggle_out_b: assert property (compare_b_value_equal && aq_cfg.act_b == ACT_TOGGLE |=> pwm_out_b != $past(pwm_out_b))
      else $error("Toggle action did not invert output B.");
   a_idle_hold: assert property (!compare_b_value_equal |=> $stable(pwm_out_a) && $stable(pwm_out_b))
      else $error("Output moved without a compare B event.");
endmodule : pcmpb_aq
`default_nettype wire

//--- hw/pcmpb_top.sv
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Active value compared with count every clock.
// - Equal values raise the compare B event.
// - Event goes to action logic per output.
// - Actions: none, low, high, invert.
// - Mode bit picks shadow; shadow after reset.
// - Mode 0: accesses reach the shadow copy.
// - Load select picks the shadow load event.
// - Pending flag shows unloaded shadow value.
// - Mode 1: accesses reach active copy directly.
// - One address serves both copies.
// - Load codes: zero, period, both, freeze.
// - Load clears pending; writes overwrite shadow.
module pcmpb_top
   import pcmpb_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Write address channel.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data channel.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read address channel.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // Read data channel.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Time-base counter.
   input wire pcmpb_tb_t timebase,
   // Compare event and qualified outputs.
   output logic compare_b_value_equal_evt,
   output logic pwm_out_a,
   output logic pwm_out_b
);

   // ************************************************
   // State
   // ************************************************

   // Whole state of the register side.
   typedef struct packed {
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] shadow;
      logic [15:0] active;
      logic pending;
      logic direct;
      pcmpb_load_t load_sel;
      pcmpb_aqcfg_t aq_cfg;
   } pcmpb_state_t;

   pcmpb_state_t st_r;
   pcmpb_state_t st_nxt;

   // Helper signals.
   logic wr_go;
   logic wr_compare_b_value;
   logic wr_ctrl;
   logic wr_act;
   logic rd_go;
   logic load_stb;
   logic compare_b_value_equal;
   logic [15:0] active_val;
   logic [15:0] shadow_val;
   logic [15:0] compare_b_value_sel;
   logic [15:0] compare_b_value_wr_val;
   logic [15:0] ctrl_word;
   logic [15:0] ctrl_wr_val;
   logic [15:0] act_word;
   logic [15:0] act_wr_val;
   logic [31:0] rd_word;

   // True when the address selects a defined register.
   function automatic logic reg_mapped(input logic [7:0] addr);
      logic [5:0] idx;
      idx = addr[7:2];
      return (idx == OFF_COMPARE_B_VALUE[7:2]) || (idx == OFF_CTRL[7:2]) || (idx == OFF_ACT[7:2])
         || (idx == OFF_STAT[7:2]) || (idx == OFF_ACTV[7:2]);
   endfunction : reg_mapped

   // ************************************************
   // Register views
   // ************************************************

   // Copies of the compare values for the assertions.
   assign active_val = st_r.active;
   assign shadow_val = st_r.shadow;

   // The mode bit alone picks which copy the shared address reaches.
   assign compare_b_value_sel = st_r.direct ? st_r.active : st_r.shadow;

   // Control word as software sees it, with the pending flag read only.
   always_comb begin
      ctrl_word = '0;
      ctrl_word[POS_PEND] = st_r.pending;
      ctrl_word[POS_DIRECT] = st_r.direct;
      ctrl_word[POS_LOAD +: 2] = st_r.load_sel;
   end

   // Action word for both outputs.
   always_comb begin
      act_word = '0;
      act_word[POS_ACT_A +: 2] = st_r.aq_cfg.act_a;
      act_word[POS_ACT_B +: 2] = st_r.aq_cfg.act_b;
   end

   // Merged write values, honouring the byte strobes.
   assign compare_b_value_wr_val = merge16(compare_b_value_sel, st_r.w_data, st_r.w_strb);
   assign ctrl_wr_val = merge16(ctrl_word, st_r.w_data, st_r.w_strb);
   assign act_wr_val = merge16(act_word, st_r.w_data, st_r.w_strb);

   // ************************************************
   // Bus decode
   // ************************************************

   // A write goes ahead once both halves are held and no answer is waiting.
   assign wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;
   assign wr_compare_b_value = wr_go && (st_r.aw_addr[7:2] == OFF_COMPARE_B_VALUE[7:2]);
   assign wr_ctrl = wr_go && (st_r.aw_addr[7:2] == OFF_CTRL[7:2]);
   assign wr_act = wr_go && (st_r.aw_addr[7:2] == OFF_ACT[7:2]);
   assign rd_go = s_axi_arvalid && s_axi_arready;

   // Read multiplexer; unmapped words read as zero.
   always_comb begin
      rd_word = '0;
      unique case (s_axi_araddr[7:2])
         OFF_COMPARE_B_VALUE[7:2]: rd_word[15:0] = compare_b_value_sel;
         OFF_CTRL[7:2]: rd_word[15:0] = ctrl_word;
         OFF_ACT[7:2]: rd_word[15:0] = act_word;
         OFF_STAT[7:2]: rd_word[2:0] = {compare_b_value_equal_evt, pwm_out_b, pwm_out_a};
         OFF_ACTV[7:2]: rd_word[15:0] = st_r.active;
         default: rd_word = '0;
      endcase
   end

   // ************************************************
   // Next state
   // ************************************************

   // Bus channels and compare registers.
   always_comb begin
      st_nxt = st_r;
      // Address and data are taken in either order.
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.w_held = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end
      // The response stays up until the master takes it.
      if (s_axi_bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (wr_go) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = reg_mapped(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      // Read data are captured when the address is taken.
      if (s_axi_rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (rd_go) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = rd_word;
         st_nxt.rresp = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      // Shadow to active transfer in the clock of the selected event.
      if (load_stb) begin
         st_nxt.active = st_r.shadow;
         st_nxt.pending = 1'b0;
      end
      // A write that meets a load still leaves the flag set.
      if (wr_compare_b_value && !st_r.direct) begin
         st_nxt.shadow = compare_b_value_wr_val;
         st_nxt.pending = 1'b1;
      end
      // Immediate mode bypasses the shadow altogether.
      if (wr_compare_b_value && st_r.direct) begin
         st_nxt.active = compare_b_value_wr_val;
      end
      if (wr_ctrl) begin
         st_nxt.direct = ctrl_wr_val[POS_DIRECT];
         st_nxt.load_sel = pcmpb_load_t'(ctrl_wr_val[POS_LOAD +: 2]);
      end
      if (wr_act) begin
         st_nxt.aq_cfg.act_a = pcmpb_act_t'(act_wr_val[POS_ACT_A +: 2]);
         st_nxt.aq_cfg.act_b = pcmpb_act_t'(act_wr_val[POS_ACT_B +: 2]);
      end
   end

   // State register; shadow mode after reset.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.shadow <= RST_COMPARE_B_VALUE;
         st_r.active <= RST_COMPARE_B_VALUE;
         st_r.direct <= RST_DIRECT;
         st_r.load_sel <= LOAD_ZERO;
         st_r.aq_cfg <= {ACT_NONE, ACT_NONE};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Bus outputs.
   assign s_axi_awready = !st_r.aw_held;
   assign s_axi_wready = !st_r.w_held;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;

   // ************************************************
   // Compare and action logic
   // ************************************************

   // Match detection and load strobe generation.
   pcmpb_load u_load (
      .clk(clk),
      .rst_n(rst_n),
      .timebase(timebase),
      .active_val(st_r.active),
      .direct(st_r.direct),
      .load_sel(st_r.load_sel),
      .compare_b_value_equal(compare_b_value_equal),
      .load_stb(load_stb),
      .compare_b_value_equal_evt(compare_b_value_equal_evt)
   );

   // Output actions at each compare B event.
   pcmpb_aq u_aq (
      .clk(clk),
      .rst_n(rst_n),
      .compare_b_value_equal(compare_b_value_equal),
      .aq_cfg(st_r.aq_cfg),
      .pwm_out_a(pwm_out_a),
      .pwm_out_b(pwm_out_b)
   );

   // ************************************************
   // Checks
   // ************************************************

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // A shadow mode write with no load in the same clock.
   sequence s_shadow_write;
      wr_compare_b_value && !st_r.direct && !load_stb;
   endsequence

   // A read of the compare B address taken by the slave.
   sequence s_read_compare_b_value;
      rd_go && (s_axi_araddr[7:2] == OFF_COMPARE_B_VALUE[7:2]);
   endsequence

   // Both halves of a write have been taken.
   sequence s_write_pair;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
   endsequence

   a_direct_write: assert property (wr_compare_b_value && st_r.direct |=> active_val == $past(compare_b_value_wr_val))
      else $error("Immediate write did not reach the active value.");

   a_shadow_write: assert property (s_shadow_write |=> st_r.pending && active_val == $past(active_val))
      else $error("Shadow write touched the active value or left pending clear.");

   a_load_copy: assert property (load_stb && !wr_compare_b_value |=> active_val == $past(shadow_val) && !st_r.pending)
      else $error("Load strobe did not move the shadow into the active value.");

   a_direct_noload: assert property (st_r.direct |-> !load_stb)
      else $error("Load strobe in immediate mode.");

   a_read_copy: assert property (s_read_compare_b_value |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(compare_b_value_sel))
      else $error("Compare B read returned the wrong copy.");

   a_write_resp: assert property (s_write_pair |=> ##1 s_axi_bvalid)
      else $error("Write response missing two clocks after the write.");

   a_mode_stable: assert property (!wr_ctrl |=> $stable(st_r.direct))
      else $error("Mode bit changed without a control write.");

   a_pending_hold: assert property (st_r.pending && !load_stb |=> st_r.pending)
      else $error("Pending flag cleared without a load.");

   // A shadow mode write that meets a load in the same clock.
   sequence s_write_meets_load;
      wr_compare_b_value && !st_r.direct && load_stb;
   endsequence

   // The load takes the old shadow; the new value waits with the flag set.
   a_write_meets_load: assert property (s_write_meets_load |=>
      active_val == $past(shadow_val) && shadow_val == $past(compare_b_value_wr_val) && st_r.pending)
      else $error("Write meeting a load lost a value or cleared pending.");

   // The active value moves only on a load or an immediate write.
   a_active_hold: assert property (!load_stb && !(wr_compare_b_value && st_r.direct) |=> $stable(active_val))
      else $error("Active value changed without a load or immediate write.");

   // Immediate writes leave the pending flag alone.
   a_pending_direct: assert property (wr_compare_b_value && st_r.direct |=> $stable(st_r.pending))
      else $error("Immediate write changed the pending flag.");

   // A waiting write response holds until the master takes it.
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped or changed while waiting.");

   // Waiting read data hold until the master takes them.
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped or changed while waiting.");

   // A taken read address is answered at the next clock.
   a_read_answer: assert property (rd_go |=> s_axi_rvalid)
      else $error("Read answer missing one clock after the address.");

endmodule : pcmpb_top
`default_nettype wire

//--- sim/pcmpb_timebase_count_model.sv
`timescale 1ns/10ps
`default_nettype none
module pcmpb_timebase_count_model
   import pcmpb_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Counter control from the bench.
   input wire logic run,
   input wire logic [15:0] period,
   input wire logic [15:0] hold_val,
   // Time-base towards the compare block.
   output var pcmpb_tb_t timebase
);
   // ********
   // Up counter
   // ********
   logic [15:0] count_r;

   // Counts up to the period and wraps; when stopped it takes the held value, so the bench can place any count.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= 16'h0000;
      end else if (!run) begin
         count_r <= hold_val;
      end else if (count_r >= period) begin
         count_r <= 16'h0000;
      end else begin
         count_r <= count_r + 16'h0001;
      end
   end

   // The period is passed on as the bench sets it.
   assign timebase = '{timebase_count: count_r, timebase_period: period};
endmodule : pcmpb_timebase_count_model
`default_nettype wire

//--- sim/tb_pwm_compare_b_shadowed.sv
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_compare_b_shadowed;
   import pcmpb_pkg::*;
   // ********
   // Signals
   // ********
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] r;} pcmpb_row_t;
   logic clk = 1'b0, rst_n = 1'b0, run = 1'b0;
   logic [15:0] period = 16'h2000, hold_val = 16'h1234, act_exp = 16'h0000;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'h3;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, evt, out_a, out_b, exp_a = 1'b0, exp_b = 1'b0;
   logic [1:0] bresp, rresp, rr;
   pcmpb_tb_t tb_bus;
   int bad_count = 0, check_count = 0, n;
   pcmpb_act_t acts_a [4] = '{ACT_SET, ACT_TOGGLE, ACT_NONE, ACT_CLEAR};
   pcmpb_act_t acts_b [4] = '{ACT_CLEAR, ACT_TOGGLE, ACT_SET, ACT_TOGGLE};
   pcmpb_row_t rows [13] = '{
      '{1'b0, OFF_COMPARE_B_VALUE, 32'h0, 32'h0, RESP_OKAY}, '{1'b0, OFF_CTRL, 32'h0, 32'h0, RESP_OKAY},
      '{1'b0, 8'h14, 32'h0, 32'h0, RESP_SLVERR}, '{1'b1, 8'h14, 32'hffff, 32'h0, RESP_SLVERR},
      '{1'b1, OFF_COMPARE_B_VALUE, 32'h0100, 32'h0, RESP_OKAY}, '{1'b0, OFF_COMPARE_B_VALUE, 32'h0, 32'h0100, RESP_OKAY},
      '{1'b0, OFF_ACTV, 32'h0, 32'h0, RESP_OKAY}, '{1'b0, OFF_CTRL, 32'h0, 32'h0200, RESP_OKAY},
      '{1'b1, OFF_COMPARE_B_VALUE, 32'h0155, 32'h0, RESP_OKAY}, '{1'b0, OFF_COMPARE_B_VALUE, 32'h0, 32'h0155, RESP_OKAY},
      '{1'b0, OFF_CTRL, 32'h0, 32'h0200, RESP_OKAY}, '{1'b1, OFF_CTRL, 32'h000c, 32'h0, RESP_OKAY},
      '{1'b0, OFF_CTRL, 32'h0, 32'h020c, RESP_OKAY}};

   // Clock of 100 ns.
   always #50 clk = ~clk;

   pcmpb_timebase_count_model i_pcmpb_timebase_count_model (.clk(clk), .rst_n(rst_n), .run(run), .period(period),
      .hold_val(hold_val), .timebase(tb_bus));

   pcmpb_top i_pcmpb_top (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timebase(tb_bus),
      .compare_b_value_equal_evt(evt), .pwm_out_a(out_a), .pwm_out_b(out_b));

   // ********
   // Tasks
   // ********
   // Compares a seen value with the expected one and counts both.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
      end
   endtask : chk

   // One bus write; each half is released at the edge that takes it.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && k < 50);
      r = bresp;
      bready <= 1'b0;
      if (!bvalid) chk(32'h0, 32'h1, "write response timeout");
   endtask : axi_wr

   // One bus read; the address is released at the edge that takes it.
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && k < 50);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (!rvalid) chk(32'h0, 32'h1, "read data timeout");
   endtask : axi_rd

   // Places one count value on the time-base for exactly one cycle.
   task automatic tb_pulse(input logic [15:0] v);
      @(posedge clk);
      hold_val <= v;
      @(posedge clk);
      hold_val <= 16'h1234;
      @(posedge clk);
   endtask : tb_pulse

   // Level of an output after one action.
   function automatic logic act_next(input logic cur, input pcmpb_act_t a);
      case (a)
         ACT_CLEAR: return 1'b0;
         ACT_SET: return 1'b1;
         ACT_TOGGLE: return !cur;
         default: return cur;
      endcase
   endfunction : act_next

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end

   // ********
   // Main sequence
   // ********
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // Register table rows: reset values, shadow writes, pending flag, unmapped place.
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            axi_wr(rows[i].a, rows[i].d, rr);
         end else begin
            axi_rd(rows[i].a, rd, rr);
            chk(rd, rows[i].x, "read data");
         end
         chk({30'h0, rr}, {30'h0, rows[i].r}, "response");
      end
      // Every load code: the shadow is copied only at the events that the code names.
      for (int c = 0; c < 4; c++) begin
         axi_wr(OFF_CTRL, 32'(c) << POS_LOAD, rr);
         axi_wr(OFF_COMPARE_B_VALUE, 32'h0300 + 32'(c), rr);
         tb_pulse(TB_ZERO);
         if (c == 0 || c == 2) act_exp = 16'h0300 + 16'(c);
         axi_rd(OFF_ACTV, rd, rr);
         chk(rd, {16'h0, act_exp}, "load at zero");
         tb_pulse(period);
         if (c == 1 || c == 2) act_exp = 16'h0300 + 16'(c);
         axi_rd(OFF_ACTV, rd, rr);
         chk(rd, {16'h0, act_exp}, "load at period");
         axi_rd(OFF_CTRL, rd, rr);
         chk({31'h0, rd[POS_PEND]}, 32'(c == 3), "pending flag");
      end
      // Direct mode: the single address reaches the active copy.
      axi_wr(OFF_CTRL, 32'h1 << POS_DIRECT, rr);
      axi_wr(OFF_COMPARE_B_VALUE, 32'h0500, rr);
      axi_rd(OFF_COMPARE_B_VALUE, rd, rr);
      chk(rd, 32'h0500, "direct readback");
      axi_rd(OFF_ACTV, rd, rr);
      chk(rd, 32'h0500, "direct active");
      // Each action on output A, and clear, set and toggle on output B, at a match.
      for (int k = 0; k < 4; k++) begin
         axi_wr(OFF_ACT, {28'h0, acts_b[k], acts_a[k]}, rr);
         exp_a = act_next(exp_a, acts_a[k]);
         exp_b = act_next(exp_b, acts_b[k]);
         tb_pulse(16'h0500);
         #1;
         chk({30'h0, out_b, out_a}, {30'h0, exp_b, exp_a}, "output levels");
         chk({31'h0, evt}, 32'h1, "match event");
         @(posedge clk);
         #1;
         chk({31'h0, evt}, 32'h0, "event ends");
         axi_rd(OFF_STAT, rd, rr);
         chk(rd, {29'h0, 1'b0, exp_b, exp_a}, "status word");
      end
      // Free-running count: one event per period.
      axi_wr(OFF_COMPARE_B_VALUE, 32'h0010, rr);
      @(posedge clk);
      period <= 16'h0020;
      run <= 1'b1;
      n = 0;
      repeat (66) begin
         @(posedge clk);
         #1;
         if (evt === 1'b1) n++;
      end
      chk(32'(n), 32'h2, "events while running");
      // A write meeting a zero-count load: the old shadow loads and the flag stays set.
      @(posedge clk);
      run <= 1'b0;
      axi_wr(OFF_CTRL, 32'h0, rr);
      fork
         axi_wr(OFF_COMPARE_B_VALUE, 32'h0600, rr);
         tb_pulse(TB_ZERO);
      join
      axi_rd(OFF_ACTV, rd, rr);
      chk(rd, 32'h0303, "load beside a write");
      axi_rd(OFF_CTRL, rd, rr);
      chk(rd, 32'h0200, "pending after collision");
      axi_rd(OFF_COMPARE_B_VALUE, rd, rr);
      chk(rd, 32'h0600, "shadow after collision");
      // Reset in mid-run: shadow mode, empty flag and zero values return.
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      axi_rd(OFF_CTRL, rd, rr);
      chk(rd, 32'h0, "control after reset");
      axi_rd(OFF_ACTV, rd, rr);
      chk(rd, 32'h0, "active after reset");
      // Only the upper byte lane is written.
      wstrb <= 4'h2;
      axi_wr(OFF_COMPARE_B_VALUE, 32'haaff, rr);
      axi_rd(OFF_COMPARE_B_VALUE, rd, rr);
      chk(rd, 32'haa00, "byte lane write");
      tally_and_finish();
   end
endmodule : tb_pwm_compare_b_shadowed
`default_nettype wire
